//--- wakeup_params.svh
/*
 * Register indexes, field layout, reset values and bus answer codes of the
 * upper wakeup source configuration block.
 * Assumes it is included by bare name from any file that needs these constants.
 */
`ifndef WAKEUP_PARAMS_SVH
`define WAKEUP_PARAMS_SVH

`define WK_ADDR_W        8
`define WK_DATA_W        32
`define WK_REG_W         8
`define WK_PIN_N         8
`define WK_MOD_N         8
`define WK_FIELD_W       2
`define WK_IDX_W         6
`define WK_IDX_PIN_CFG_A 6'h02
`define WK_IDX_PIN_CFG_B 6'h03
`define WK_IDX_MOD_EN    6'h04
`define WK_IDX_PIN_FLAGS 6'h06
`define WK_IDX_MOD_STAT  6'h07
`define WK_IDX_IRQ_MASK  6'h10
`define WK_RST_PIN_CFG   8'h00
`define WK_RST_MOD_EN    8'h00
`define WK_RST_IRQ_MASK  8'h00
`define WK_RESP_OKAY     2'b00
`define WK_RESP_SLVERR   2'b10

`endif

//--- wakeup_pkg.sv
/*
 * Types shared by the upper wakeup source configuration block.
 * Assumes wakeup_params.svh is available on the include path.
 */
`default_nettype none

`include "wakeup_params.svh"

package wakeup_pkg;

    typedef enum logic [`WK_FIELD_W-1:0] {
        EDGE_OFF  = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_ANY  = 2'b11
    } edge_cfg_e;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic hit;
    } pin_det_s;

    typedef struct packed {
        logic                  awHave;
        logic [`WK_ADDR_W-1:0] awAddr;
        logic                  wHave;
        logic [`WK_REG_W-1:0]  wData;
        logic                  wLane;
        logic                  bValid;
        logic [1:0]            bResp;
        logic                  rValid;
        logic [`WK_REG_W-1:0]  rData;
        logic [1:0]            rResp;
        logic [`WK_REG_W-1:0]  pinCfgA;
        logic [`WK_REG_W-1:0]  pinCfgB;
        logic [`WK_REG_W-1:0]  modEn;
        logic [`WK_REG_W-1:0]  irqMask;
        logic                  wakeReq;
        logic                  irqFlow;
        logic                  rstFlow;
    } wk_state_s;

endpackage : wakeup_pkg

`default_nettype wire

//--- flag_bank_if.sv
/*
 * Carrier between the wakeup core and its sticky flag bank.
 * Assumes one owner drives set and clear masks on the bank's clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface flag_bank_if #(parameter int W = 8);
    logic [W-1:0] setMask;
    logic [W-1:0] clrMask;
    logic [W-1:0] flags;
    modport bank  (input setMask, input clrMask, output flags);
    modport owner (output setMask, output clrMask, input flags);
endinterface : flag_bank_if

`default_nettype wire

//--- wake_pin_detect.sv
/*
 * One external wakeup pin: two-stage synchroniser and selectable edge detector.
 * Assumes the pin is asynchronous to clk and the edge selection is quasi-static.
 */
`timescale 1ns/1ns
`default_nettype none

module wake_pin_detect (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  pinAsync,
    input  wire wakeup_pkg::edge_cfg_e cfg,
    output logic                       hit
);
    import wakeup_pkg::*;

    pin_det_s s_r;
    pin_det_s s_nxt;

    always_comb begin
        s_nxt       = s_r;
        s_nxt.sync1 = pinAsync;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev  = s_r.sync2;
        case (cfg)
            EDGE_RISE: s_nxt.hit = s_r.sync2 & ~s_r.prev; // RL2
            EDGE_FALL: s_nxt.hit = ~s_r.sync2 & s_r.prev; // RL3
            EDGE_ANY:  s_nxt.hit = s_r.sync2 ^ s_r.prev; // RL4
            default:   s_nxt.hit = 1'b0; // RL1
        endcase
    end

    // A pin already high when reset is released reads as one rising edge.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hit = s_r.hit;

endmodule : wake_pin_detect

`default_nettype wire

//--- sticky_flag_bank.sv
/*
 * Bank of sticky flags, set by hardware and cleared by write-one.
 * Assumes the owner presents clear masks only for one cycle per write.
 */
`timescale 1ns/1ns
`default_nettype none

module sticky_flag_bank #(
    parameter int W = 8
) (
    input  wire logic   clk,
    input  wire logic   nrst,
    flag_bank_if.bank   fb
);
    typedef struct packed {
        logic [W-1:0] flags;
    } bank_s;

    bank_s s_r;
    bank_s s_nxt;

    // A set in the same cycle as its clear wins, so no event is lost.
    always_comb begin
        s_nxt       = s_r;
        s_nxt.flags = (s_r.flags & ~fb.clrMask) | fb.setMask; // RL13
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fb.flags = s_r.flags;

endmodule : sticky_flag_bank

`default_nettype wire

//--- wakeup_source_enable_upper.sv
/*
 * Upper wakeup source configuration: edge selection for wakeup pins 8 to 15,
 * enables for internal module flags 0 to 7, sticky pin flags with a masked
 * interrupt, and the wake request toward the power controller, behind an
 * AXI4-Lite slave.
 * Assumes nrst is asserted only by a chip reset that is not a very-low-leakage
 * wake; the mode inputs and module flags come from logic on clk.
 */
// Local design decision: the AXI4-Lite interface to the registers.
// Contract
// RL1: A pin field holding 00 keeps that pin out of wakeup entirely.
// RL2: A pin field holding 01 enables the pin and detects rising edges only.
// RL3: A pin field holding 10 enables the pin and detects falling edges only.
// RL4: A pin field holding 11 enables the pin and detects both edges.
// RL5: The first upper pin byte holds pins 11, 10, 9 and 8 in bits 7:6, 5:4, 3:2 and 1:0.
// RL6: The second upper pin byte holds pins 15, 14, 13 and 12 in bits 7:6, 5:4, 3:2 and 1:0.
// RL7: A module enable bit at one admits its module flag as a wakeup source, at zero ignores it.
// RL8: Module enable bit n serves internal module wakeup input n for n from 7 to 0.
// RL9: A chip reset that is not a very-low-leakage wake resets all three configuration registers.
// RL10: Other reset types, a wakeup reset among them, leave the configuration untouched.
// RL11: The two pin bytes and the module byte sit at indexes 2, 3 and 4.
// RL12: All module enable bits are read-write and reset to zero.
// RL13: A latched pin flag clears by writing one and survives disabling its pin.
// RL14: A wake starts an interrupt flow from low-leakage stop and a reset flow from very-low-leakage stop.
// RL15: Any enabled pin edge or enabled asserted module flag raises one wakeup request.
`timescale 1ns/1ns
`default_nettype none

`include "wakeup_params.svh"

module wakeup_source_enable_upper #(
    parameter int PIN_N = `WK_PIN_N,
    parameter int MOD_N = `WK_MOD_N
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [`WK_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [`WK_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [`WK_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [`WK_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    input  wire logic [PIN_N-1:0]      wakePins,
    input  wire logic [MOD_N-1:0]      moduleWakeFlags,
    input  wire logic                  lowLeakStop,
    input  wire logic                  veryLowLeakStop,
    output logic                       wakeRequest,
    output logic                       wakeIrqFlow,
    output logic                       wakeResetFlow,
    output logic                       irq
);
    import wakeup_pkg::*;

    wk_state_s             s_r;
    wk_state_s             s_nxt;
    logic [PIN_N-1:0]      pinHit;
    logic [2*PIN_N-1:0]    pinCfgAll;
    logic [MOD_N-1:0]      modActive;
    logic                  anyWake;
    logic                  wrCommit;
    logic [`WK_IDX_W-1:0]  wrIdx;
    logic [`WK_IDX_W-1:0]  rdIdx;

    flag_bank_if #(.W(PIN_N)) pinFlags ();

    // Pin 8 lands in the low pair of the first byte, pin 15 in the top pair of the second.
    assign pinCfgAll = {s_r.pinCfgB, s_r.pinCfgA}; // RL5 RL6

    for (genvar i = 0; i < PIN_N; i++) begin : g_pin
        wake_pin_detect u_det (
            .clk      (clk),
            .nrst     (nrst),
            .pinAsync (wakePins[i]),
            .cfg      (edge_cfg_e'(pinCfgAll[`WK_FIELD_W*i +: `WK_FIELD_W])),
            .hit      (pinHit[i])
        );
    end

    sticky_flag_bank #(.W(PIN_N)) u_flags (
        .clk  (clk),
        .nrst (nrst),
        .fb   (pinFlags)
    );

    assign modActive = moduleWakeFlags & s_r.modEn; // RL7 RL8
    assign anyWake   = (|pinHit) | (|modActive); // RL15
    assign wrCommit  = s_r.awHave & s_r.wHave & ~s_r.bValid;
    assign wrIdx     = s_r.awAddr[`WK_ADDR_W-1:2];
    assign rdIdx     = s_axi_araddr[`WK_ADDR_W-1:2];

    // The flag is cleared only by software or by nrst, never by changing its pin field.
    assign pinFlags.setMask = pinHit; // RL13
    assign pinFlags.clrMask = (wrCommit && s_r.wLane && wrIdx == `WK_IDX_PIN_FLAGS)
                              ? s_r.wData : '0; // RL13

    always_comb begin
        s_nxt = s_r;
        if (s_axi_awvalid && !s_r.awHave) begin
            s_nxt.awHave = 1'b1;
            s_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.wHave) begin
            s_nxt.wHave = 1'b1;
            s_nxt.wData = s_axi_wdata[`WK_REG_W-1:0];
            s_nxt.wLane = s_axi_wstrb[0];
        end
        if (s_r.bValid && s_axi_bready) begin
            s_nxt.bValid = 1'b0;
        end
        // Only byte lane 0 carries register data; other lanes are accepted and dropped.
        if (wrCommit) begin
            s_nxt.awHave = 1'b0;
            s_nxt.wHave  = 1'b0;
            s_nxt.bValid = 1'b1;
            s_nxt.bResp  = `WK_RESP_OKAY;
            case (wrIdx)
                `WK_IDX_PIN_CFG_A: if (s_r.wLane) s_nxt.pinCfgA = s_r.wData; // RL11
                `WK_IDX_PIN_CFG_B: if (s_r.wLane) s_nxt.pinCfgB = s_r.wData; // RL11
                `WK_IDX_MOD_EN:    if (s_r.wLane) s_nxt.modEn   = s_r.wData; // RL11 RL12
                `WK_IDX_IRQ_MASK:  if (s_r.wLane) s_nxt.irqMask = s_r.wData;
                `WK_IDX_PIN_FLAGS: s_nxt.bResp = `WK_RESP_OKAY;
                `WK_IDX_MOD_STAT:  s_nxt.bResp = `WK_RESP_OKAY;
                default:           s_nxt.bResp = `WK_RESP_SLVERR;
            endcase
        end
        if (s_r.rValid && s_axi_rready) begin
            s_nxt.rValid = 1'b0;
        end
        if (s_axi_arvalid && !s_r.rValid) begin
            s_nxt.rValid = 1'b1;
            s_nxt.rResp  = `WK_RESP_OKAY;
            case (rdIdx)
                `WK_IDX_PIN_CFG_A: s_nxt.rData = s_r.pinCfgA; // RL11
                `WK_IDX_PIN_CFG_B: s_nxt.rData = s_r.pinCfgB; // RL11
                `WK_IDX_MOD_EN:    s_nxt.rData = s_r.modEn; // RL12
                `WK_IDX_PIN_FLAGS: s_nxt.rData = pinFlags.flags;
                `WK_IDX_MOD_STAT:  s_nxt.rData = modActive;
                `WK_IDX_IRQ_MASK:  s_nxt.rData = s_r.irqMask;
                default: begin
                    s_nxt.rData = '0;
                    s_nxt.rResp = `WK_RESP_SLVERR;
                end
            endcase
        end
        // Very-low-leakage stop takes precedence should both mode levels be high.
        s_nxt.wakeReq = anyWake; // RL15
        s_nxt.rstFlow = anyWake & veryLowLeakStop; // RL14
        s_nxt.irqFlow = anyWake & lowLeakStop & ~veryLowLeakStop; // RL14
    end

    // Only chip reset reaches nrst; wakeup and other resets are kept off it.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r         <= '0;
            s_r.pinCfgA <= `WK_RST_PIN_CFG; // RL9
            s_r.pinCfgB <= `WK_RST_PIN_CFG; // RL9
            s_r.modEn   <= `WK_RST_MOD_EN; // RL9 RL12
            s_r.irqMask <= `WK_RST_IRQ_MASK;
        end else begin
            s_r <= s_nxt; // RL10
        end
    end

    assign s_axi_awready = ~s_r.awHave;
    assign s_axi_wready  = ~s_r.wHave;
    assign s_axi_bvalid  = s_r.bValid;
    assign s_axi_bresp   = s_r.bResp;
    assign s_axi_arready = ~s_r.rValid;
    assign s_axi_rvalid  = s_r.rValid;
    assign s_axi_rdata   = {{(`WK_DATA_W-`WK_REG_W){1'b0}}, s_r.rData};
    assign s_axi_rresp   = s_r.rResp;
    assign wakeRequest   = s_r.wakeReq;
    assign wakeIrqFlow   = s_r.irqFlow;
    assign wakeResetFlow = s_r.rstFlow;
    assign irq           = |(pinFlags.flags & s_r.irqMask);

endmodule : wakeup_source_enable_upper

`default_nettype wire

//--- wakeup_source_enable_upper_sva.sv
/* Checker for the upper wakeup block, bound to its top ports.
   Assumes the bench master holds bready and rready high. */
`timescale 1ns/1ns
`default_nettype none
module wakeup_source_enable_upper_sva #(
    parameter int PIN_N = 8,
    parameter int MOD_N = 8
) (
    input wire logic             clk,
    input wire logic             nrst,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic [PIN_N-1:0] wakePins,
    input wire logic [MOD_N-1:0] moduleWakeFlags,
    input wire logic             lowLeakStop,
    input wire logic             veryLowLeakStop,
    input wire logic             wakeRequest,
    input wire logic             wakeIrqFlow,
    input wire logic             wakeResetFlow,
    input wire logic             irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_b_after_w: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
        else $error("write answered without a taken address and data");
    chk_read_one: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer still pending after its handshake");
    chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data above the register byte not zero");
    chk_reset_flow: assert property (wakeResetFlow |-> wakeRequest && $past(veryLowLeakStop))
        else $error("reset flow without wake from the deepest stop");
    chk_irq_flow: assert property (wakeIrqFlow |-> wakeRequest && $past(lowLeakStop && !veryLowLeakStop))
        else $error("interrupt flow without wake from low leakage stop");
    chk_quiet_wake: assert property ((moduleWakeFlags == '0 && $stable(wakePins)) [*5] |=> !wakeRequest)
        else $error("wake request with no pin change and no module flag");
    chk_irq_rise: assert property ($rose(irq) |-> s_axi_bvalid || wakeRequest)
        else $error("interrupt rose without a pin wake or a mask write");
    chk_irq_fall: assert property ($fell(irq) |-> s_axi_bvalid)
        else $error("interrupt fell without a register write");
endmodule : wakeup_source_enable_upper_sva
bind wakeup_source_enable_upper wakeup_source_enable_upper_sva #(.PIN_N(PIN_N), .MOD_N(MOD_N))
    wakeup_source_enable_upper_sva_i (.*);
`default_nettype wire

//--- wake_partner.sv
/* External wakeup pins and internal module flags facing the block.
   Assumes the bench sets the wanted levels on pinLvl and modLvl. */
`timescale 1ns/1ns
`default_nettype none
module wake_partner (
    input  wire logic       clk,
    input  wire logic [7:0] pinLvl,
    input  wire logic [7:0] modLvl,
    output logic      [7:0] wakePins,
    output logic      [7:0] moduleWakeFlags
);
    // Pins move off the edge, as an unrelated source would; levels stay unknown until the first edge.
    always @(posedge clk) wakePins <= #3 pinLvl;
    always @(posedge clk) moduleWakeFlags <= modLvl;
endmodule : wake_partner
`default_nettype wire

//--- wakeup_source_enable_upper_tb.sv
/* Self-checking bench of the upper wakeup block.
   Assumes the checker is bound and the partner drives pins and flags. */
`timescale 1ns/1ns
`default_nettype none
module wakeup_source_enable_upper_tb;
    logic        clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        lowLeakStop, veryLowLeakStop, wakeRequest, wakeIrqFlow, wakeResetFlow, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, wakePins, moduleWakeFlags, pinLvl, modLvl;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_wdata, s_axi_rdata, lfsr;
    logic [15:0] cfg;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          error_cnt, checked;
    wakeup_source_enable_upper wakeup_source_enable_upper_i (.*);
    wake_partner wake_partner_i (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : rnd
    function automatic logic [33:0] ok(input logic [7:0] v);
        return {26'h0, v};
    endfunction : ok
    // Expected flags: rising uses the low bit of each field, falling the high.
    function automatic logic [7:0] hits(input logic [15:0] c, input int f);
        for (int i = 0; i < 8; i++) hits[i] = c[2 * i + f];
    endfunction : hits
    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask : cmp
    task automatic conclude;
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {lfsr[31:8], d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
    endtask : rd
    // Answers are compared where they appear, against the oldest note.
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) cmp({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    end
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, lowLeakStop, veryLowLeakStop, nrst} = '0;
        {s_axi_awaddr, s_axi_araddr, pinLvl, modLvl, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready, lfsr} = {4'hF, 2'b11, 32'h62C3};
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 3; k++) rd(8'h08 + 8'(4 * k), ok(8'h00));
        rd(8'h24, {2'b10, 32'h0});
        wr(8'h24, 8'hFF, 2'b10);
        repeat (4) begin
            lfsr = rnd(lfsr);
            wr(8'h08, lfsr[7:0], 2'b00);
            wr(8'h0C, lfsr[15:8], 2'b00);
            wr(8'h10, lfsr[23:16], 2'b00);
            rd(8'h08, ok(lfsr[7:0]));
            rd(8'h0C, ok(lfsr[15:8]));
            rd(8'h10, ok(lfsr[23:16]));
        end
        wr(8'h40, 8'hFF, 2'b00);
        for (int k = 0; k < 2; k++) begin
            cfg = k ? 16'hE41B : 16'h1BE4;
            wr(8'h08, cfg[7:0], 2'b00);
            wr(8'h0C, cfg[15:8], 2'b00);
            for (int f = 0; f < 2; f++) begin
                pinLvl <= f ? 8'h00 : 8'hFF;
                idle(8);
                cmp(irq, |hits(cfg, f));
                rd(8'h18, ok(hits(cfg, f)));
                wr(8'h18, 8'hFF, 2'b00);
                cmp(irq, 1'b0);
            end
        end
        pinLvl <= 8'hFF;
        idle(8);
        wr(8'h08, 8'h00, 2'b00);
        wr(8'h0C, 8'h00, 2'b00);
        pinLvl <= 8'h00;
        idle(8);
        rd(8'h18, ok(hits(cfg, 0)));
        wr(8'h40, 8'h00, 2'b00);
        cmp(irq, 1'b0);
        wr(8'h18, 8'hFF, 2'b00);
        for (int k = 0; k < 4; k++) begin
            lfsr = rnd(lfsr);
            {veryLowLeakStop, lowLeakStop} <= 2'(k);
            wr(8'h10, lfsr[7:0] | 8'h01, 2'b00);
            modLvl <= lfsr[15:8] | 8'h01;
            idle(3);
            cmp(wakeRequest, 1'b1);
            cmp({wakeResetFlow, wakeIrqFlow}, {k > 1, k == 1});
            rd(8'h1C, ok((lfsr[7:0] | 8'h01) & (lfsr[15:8] | 8'h01)));
            modLvl <= 8'h00;
        end
        // A wake that raised the reset flow must leave the module enable byte as it was.
        rd(8'h10, ok(lfsr[7:0] | 8'h01));
        wr(8'h08, 8'h5A, 2'b00);
        s_axi_wstrb <= 4'hE;
        wr(8'h08, 8'hFF, 2'b00);
        s_axi_wstrb <= 4'hF;
        rd(8'h08, ok(8'h5A));
        wr(8'h0C, 8'hA5, 2'b00);
        wr(8'h10, 8'hC3, 2'b00);
        nrst <= 1'b0;
        idle(2);
        nrst <= 1'b1;
        @(posedge clk);
        rd(8'h08, ok(8'h00));
        rd(8'h0C, ok(8'h00));
        rd(8'h10, ok(8'h00));
        idle(2);
        conclude();
    end
endmodule : wakeup_source_enable_upper_tb
`default_nettype wire
